// [logic/mit_pkg.sv]
package mit_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PH_FIRST         = 2'h0;
  localparam logic [1:0] PH_INSTR         = 2'h1;
  localparam logic [1:0] PH_LAST          = 2'(PHASES_PER_CYCLE - 1);

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W        = 10;
  localparam int DA_W        = 7;
  localparam int DMEM_DEPTH  = 128;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;

  // ----------------------------------------------------------------
  // instruction word fields
  // ----------------------------------------------------------------
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 10;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam int ADR_MSB = 6;
  localparam int ADR_LSB = 0;
  localparam int IMM_MSB = 7;
  localparam int TGT_MSB = 9;

  // ----------------------------------------------------------------
  // special data addresses and status layout
  // ----------------------------------------------------------------
  localparam logic [DA_W-1:0] ADDR_PC_LOW = 7'h02;
  localparam logic [DA_W-1:0] ADDR_TBLH   = 7'h08;
  localparam logic [DA_W-1:0] ADDR_STATUS = 7'h0a;
  localparam int ST_Z  = 0;
  localparam int ST_C  = 1;
  localparam int ST_AC = 2;
  localparam int ST_OV = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] RST_PC     = 10'h000;
  localparam logic [7:0]      RST_ACC    = 8'h00;
  localparam logic [3:0]      RST_STATUS = 4'h0;
  localparam logic [15:0]     RST_INSTR  = 16'h0000;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_NOP      = 6'h00;
  localparam logic [5:0] OP_MOV_AM   = 6'h01;
  localparam logic [5:0] OP_MOV_MA   = 6'h02;
  localparam logic [5:0] OP_MOV_AX   = 6'h03;
  localparam logic [5:0] OP_ADD_AM   = 6'h04;
  localparam logic [5:0] OP_ADDM     = 6'h05;
  localparam logic [5:0] OP_ADD_AX   = 6'h06;
  localparam logic [5:0] OP_ADC_AM   = 6'h07;
  localparam logic [5:0] OP_ADCM     = 6'h08;
  localparam logic [5:0] OP_SUB_AX   = 6'h09;
  localparam logic [5:0] OP_SUB_AM   = 6'h0a;
  localparam logic [5:0] OP_SUBM     = 6'h0b;
  localparam logic [5:0] OP_SBC_AM   = 6'h0c;
  localparam logic [5:0] OP_SBCM     = 6'h0d;
  localparam logic [5:0] OP_AND_AM   = 6'h0e;
  localparam logic [5:0] OP_OR_AM    = 6'h0f;
  localparam logic [5:0] OP_XOR_AM   = 6'h10;
  localparam logic [5:0] OP_ANDM     = 6'h11;
  localparam logic [5:0] OP_ORM      = 6'h12;
  localparam logic [5:0] OP_XORM     = 6'h13;
  localparam logic [5:0] OP_AND_AX   = 6'h14;
  localparam logic [5:0] OP_OR_AX    = 6'h15;
  localparam logic [5:0] OP_XOR_AX   = 6'h16;
  localparam logic [5:0] OP_COMPL_M  = 6'h17;
  localparam logic [5:0] OP_COMPLA_M = 6'h18;
  localparam logic [5:0] OP_ADDONE_M = 6'h19;
  localparam logic [5:0] OP_ADDONEA  = 6'h1a;
  localparam logic [5:0] OP_SUBONE_M = 6'h1b;
  localparam logic [5:0] OP_SUBONEA  = 6'h1c;
  localparam logic [5:0] OP_ROTR_M   = 6'h1d;
  localparam logic [5:0] OP_ROTL_M   = 6'h1e;
  localparam logic [5:0] OP_ROTRC_M  = 6'h1f;
  localparam logic [5:0] OP_ROTLC_M  = 6'h20;
  localparam logic [5:0] OP_CLR_M    = 6'h21;
  localparam logic [5:0] OP_SET_BIT  = 6'h22;
  localparam logic [5:0] OP_CLR_BIT  = 6'h23;
  localparam logic [5:0] OP_SZ_M     = 6'h24;
  localparam logic [5:0] OP_SNZ_M    = 6'h25;
  localparam logic [5:0] OP_SZ_BIT   = 6'h26;
  localparam logic [5:0] OP_SNZ_BIT  = 6'h27;
  localparam logic [5:0] OP_JMP      = 6'h28;
  localparam logic [5:0] OP_CALL     = 6'h29;
  localparam logic [5:0] OP_SUBEXIT  = 6'h2a;
  localparam logic [5:0] OP_INTEXIT  = 6'h2b;
  localparam logic [5:0] OP_TABRD    = 6'h2c;

  typedef enum logic [2:0] {
    MIT_ST_EXEC   = 3'b001,
    MIT_ST_BUBBLE = 3'b010,
    MIT_ST_TABLE  = 3'b100
  } mit_state_t;

endpackage

// [logic/mit_dmem.sv]
`timescale 1ns/1ps
module mit_dmem
  import mit_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic [DA_W-1:0] raddr,
  output logic      [7:0]      rdata,
  input  wire logic            we,
  input  wire logic [DA_W-1:0] waddr,
  input  wire logic [7:0]      wdata
);

  // ----------------------------------------------------------------
  // storage with registered read
  // ----------------------------------------------------------------
  logic [7:0] mem_r [DMEM_DEPTH];
  logic [7:0] rdata_r;

  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= mem_r[raddr];
    end
  end

  assign rdata = rdata_r;

endmodule // mit_dmem

// [logic/mit_core.sv]
`timescale 1ns/1ps
// Contract
// - every instruction cycle spans exactly four system clocks
// - jump, call, exits and table read take two instruction cycles
// - writing the low program counter byte jumps and costs one extra cycle
// - skip tests take one cycle, or two when the skip happens
// - conditional skips test a memory byte or one bit
// - call saves next address, exit resumes there, jump saves nothing
// - moves: memory to acc, acc to memory, immediate to acc
// - add reports carry above 255, subtract reports borrow below 0
// - increment and decrement change the operand by exactly one
// - logic operations go through acc and set zero on zero result
// - rotates shift one bit; carry variants move outgoing bit into carry
// - bit set and clear modify one bit, others unchanged
// - add and subtract update zero, carry, aux carry and overflow
module mit_core
  import mit_pkg::*;
(
  input  wire logic            CLK_SYS,
  input  wire logic            RST_B,
  output logic      [PC_W-1:0] PROG_ADDR,
  input  wire logic [15:0]     PROG_DATA,
  output logic      [PC_W-1:0] PC_OUT,
  output logic      [7:0]      ACC_OUT,
  output logic      [3:0]      FLAGS_OUT,
  output logic      [1:0]      PHASE_OUT,
  output logic                 INSTR_DONE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mit_state_t      state_r, state_nxt;
  logic [1:0]      phase_r, phase_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [PC_W-1:0] paddr_r, paddr_nxt;
  logic [7:0]      acc_r, acc_nxt;
  logic [3:0]      status_r, status_nxt;
  logic [7:0]      tblh_r, tblh_nxt;
  logic [15:0]     instr_r, instr_nxt;
  logic [15:0]     tdata_r, tdata_nxt;
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic            done_r, done_nxt;
  logic [PC_W-1:0] stk_r [STACK_DEPTH];
  logic            push, wr_req, dmem_we, skip, redirect, arith_upd, exec;
  logic [7:0]      wdata, mem_rdata, imm, opnd, bmask;
  logic [10:0]     ar;
  logic [5:0]      op;
  logic [2:0]      bsel;
  logic [DA_W-1:0] adr;

  assign op    = instr_r[OP_MSB:OP_LSB];
  assign bsel  = instr_r[BIT_MSB:BIT_LSB];
  assign adr   = instr_r[ADR_MSB:ADR_LSB];
  assign imm   = instr_r[IMM_MSB:0];
  assign bmask = 8'h01 << bsel;
  assign exec  = (phase_r == PH_LAST) && (state_r == MIT_ST_EXEC);

  // ----------------------------------------------------------------
  // operand read
  // ----------------------------------------------------------------
  mit_dmem u_dmem (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .raddr (adr),
    .rdata (mem_rdata),
    .we    (dmem_we),
    .waddr (adr),
    .wdata (wdata)
  );

  always_comb begin
    case (adr)
      ADDR_PC_LOW: opnd = pc_r[7:0];
      ADDR_TBLH:   opnd = tblh_r;
      ADDR_STATUS: opnd = {4'h0, status_r};
      default:     opnd = mem_rdata;
    endcase
  end

  // ----------------------------------------------------------------
  // arithmetic helpers: {ov, ac, c, result}
  // ----------------------------------------------------------------
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add8 = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
  endfunction
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                       input logic bi);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} - {1'b0, b} - {8'h00, bi};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
    sub8 = {(a[7] != b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // sequencing and execution
  // ----------------------------------------------------------------
  always_comb begin
    phase_nxt  = phase_r + 2'h1;
    state_nxt  = state_r;
    pc_nxt     = pc_r;
    paddr_nxt  = paddr_r;
    acc_nxt    = acc_r;
    status_nxt = status_r;
    tblh_nxt   = tblh_r;
    instr_nxt  = instr_r;
    tdata_nxt  = tdata_r;
    sp_nxt     = sp_r;
    push       = 1'b0;
    wr_req     = 1'b0;
    wdata      = 8'h00;
    dmem_we    = 1'b0;
    skip       = 1'b0;
    redirect   = 1'b0;
    arith_upd  = 1'b0;
    ar         = 11'h000;
    done_nxt   = 1'b0;
    if (phase_r == PH_INSTR) begin
      instr_nxt = (state_r == MIT_ST_EXEC) ? PROG_DATA : instr_r;
      tdata_nxt = (state_r == MIT_ST_TABLE) ? PROG_DATA : tdata_r;
    end
    if (phase_r == PH_LAST) begin
      unique case (state_r)
        MIT_ST_EXEC: begin
          pc_nxt = pc_r + 10'h001;
          unique case (op)
            OP_MOV_AM:   acc_nxt = opnd;
            OP_MOV_MA:   begin wr_req = 1'b1; wdata = acc_r; end
            OP_MOV_AX:   acc_nxt = imm;
            OP_ADD_AM, OP_ADDM: begin ar = add8(acc_r, opnd, 1'b0); arith_upd = 1'b1; end
            OP_ADD_AX:   begin ar = add8(acc_r, imm, 1'b0); arith_upd = 1'b1; end
            OP_ADC_AM, OP_ADCM: begin ar = add8(acc_r, opnd, status_r[ST_C]); arith_upd = 1'b1; end
            OP_SUB_AX:   begin ar = sub8(acc_r, imm, 1'b0); arith_upd = 1'b1; end
            OP_SUB_AM, OP_SUBM: begin ar = sub8(acc_r, opnd, 1'b0); arith_upd = 1'b1; end
            OP_SBC_AM, OP_SBCM: begin ar = sub8(acc_r, opnd, status_r[ST_C]); arith_upd = 1'b1; end
            OP_AND_AM:   acc_nxt = acc_r & opnd;
            OP_OR_AM:    acc_nxt = acc_r | opnd;
            OP_XOR_AM:   acc_nxt = acc_r ^ opnd;
            OP_ANDM:     begin wr_req = 1'b1; wdata = acc_r & opnd; end
            OP_ORM:      begin wr_req = 1'b1; wdata = acc_r | opnd; end
            OP_XORM:     begin wr_req = 1'b1; wdata = acc_r ^ opnd; end
            OP_AND_AX:   acc_nxt = acc_r & imm;
            OP_OR_AX:    acc_nxt = acc_r | imm;
            OP_XOR_AX:   acc_nxt = acc_r ^ imm;
            OP_COMPL_M:  begin wr_req = 1'b1; wdata = ~opnd; end
            OP_COMPLA_M: acc_nxt = ~opnd;
            OP_ADDONE_M: begin wr_req = 1'b1; wdata = opnd + 8'h01; end
            OP_ADDONEA:  acc_nxt = opnd + 8'h01;
            OP_SUBONE_M: begin wr_req = 1'b1; wdata = opnd - 8'h01; end
            OP_SUBONEA:  acc_nxt = opnd - 8'h01;
            OP_ROTR_M:   begin wr_req = 1'b1; wdata = {opnd[0], opnd[7:1]}; end
            OP_ROTL_M:   begin wr_req = 1'b1; wdata = {opnd[6:0], opnd[7]}; end
            OP_ROTRC_M:  begin
              wr_req = 1'b1;
              wdata  = {status_r[ST_C], opnd[7:1]};
              status_nxt[ST_C] = opnd[0];
            end
            OP_ROTLC_M:  begin
              wr_req = 1'b1;
              wdata  = {opnd[6:0], status_r[ST_C]};
              status_nxt[ST_C] = opnd[7];
            end
            OP_CLR_M:    wr_req = 1'b1;
            OP_SET_BIT:  begin wr_req = 1'b1; wdata = opnd | bmask; end
            OP_CLR_BIT:  begin wr_req = 1'b1; wdata = opnd & ~bmask; end
            OP_SZ_M:     skip = (opnd == 8'h00);
            OP_SNZ_M:    skip = (opnd != 8'h00);
            OP_SZ_BIT:   skip = ((opnd & bmask) == 8'h00);
            OP_SNZ_BIT:  skip = ((opnd & bmask) != 8'h00);
            OP_JMP:      begin pc_nxt = instr_r[TGT_MSB:0]; redirect = 1'b1; end
            OP_CALL:     begin
              pc_nxt   = instr_r[TGT_MSB:0];
              push     = 1'b1;
              sp_nxt   = sp_r + 3'h1;
              redirect = 1'b1;
            end
            OP_SUBEXIT, OP_INTEXIT: begin
              pc_nxt   = stk_r[sp_r - 3'h1];
              sp_nxt   = sp_r - 3'h1;
              redirect = 1'b1;
            end
            OP_TABRD:    state_nxt = MIT_ST_TABLE;
            default:     acc_nxt = acc_r;
          endcase
          if ((op >= OP_AND_AM && op <= OP_SUBONEA)) begin
            status_nxt[ST_Z] = (wr_req ? wdata : acc_nxt) == 8'h00;
          end
          if (arith_upd) begin
            status_nxt = {ar[10:8], ar[7:0] == 8'h00};
            if (op == OP_ADDM || op == OP_ADCM || op == OP_SUBM || op == OP_SBCM) begin
              wr_req = 1'b1;
              wdata  = ar[7:0];
            end else begin
              acc_nxt = ar[7:0];
            end
          end
          if (wr_req) begin
            if (adr == ADDR_PC_LOW) begin
              pc_nxt   = {pc_r[PC_W-1:8], wdata};
              redirect = 1'b1;
            end else if (adr == ADDR_STATUS) begin
              status_nxt = wdata[3:0];
            end else if (adr == ADDR_TBLH) begin
              tblh_nxt = wdata;
            end else begin
              dmem_we = 1'b1;
            end
          end
          if (skip) begin
            pc_nxt = pc_r + 10'h002;
          end
          if (redirect || skip) begin
            state_nxt = MIT_ST_BUBBLE;
          end
        end
        MIT_ST_BUBBLE: state_nxt = MIT_ST_EXEC;
        MIT_ST_TABLE: begin
          wdata     = tdata_r[7:0];
          dmem_we   = (adr != ADDR_PC_LOW) && (adr != ADDR_STATUS) && (adr != ADDR_TBLH);
          tblh_nxt  = tdata_r[15:8];
          state_nxt = MIT_ST_EXEC;
        end
      endcase
      done_nxt  = (state_nxt == MIT_ST_EXEC);
      paddr_nxt = (state_nxt == MIT_ST_TABLE) ? {pc_r[PC_W-1:8], acc_r} : pc_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      state_r  <= MIT_ST_EXEC;
      phase_r  <= PH_FIRST;
      pc_r     <= RST_PC;
      paddr_r  <= RST_PC;
      acc_r    <= RST_ACC;
      status_r <= RST_STATUS;
      tblh_r   <= RST_ACC;
      instr_r  <= RST_INSTR;
      tdata_r  <= RST_INSTR;
      sp_r     <= '0;
      done_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      phase_r  <= phase_nxt;
      pc_r     <= pc_nxt;
      paddr_r  <= paddr_nxt;
      acc_r    <= acc_nxt;
      status_r <= status_nxt;
      tblh_r   <= tblh_nxt;
      instr_r  <= instr_nxt;
      tdata_r  <= tdata_nxt;
      sp_r     <= sp_nxt;
      done_r   <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // return address stack
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < STACK_DEPTH; gi++) begin : g_stk
    logic [PC_W-1:0] stk_nxt;
    always_comb begin
      stk_nxt = (push && sp_r == SP_W'(gi)) ? pc_r + 10'h001 : stk_r[gi];
    end
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
        stk_r[gi] <= RST_PC;
      end else begin
        stk_r[gi] <= stk_nxt;
      end
    end
  end

  assign PROG_ADDR  = paddr_r;
  assign PC_OUT     = pc_r;
  assign ACC_OUT    = acc_r;
  assign FLAGS_OUT  = status_r;
  assign PHASE_OUT  = phase_r;
  assign INSTR_DONE = done_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  cycle_len_a: assert property (done_r |=> !done_r [*3])
    else $error("instruction cycle shorter than four clocks");
  two_cycle_a: assert property (exec && (op == OP_JMP || op == OP_CALL || op == OP_SUBEXIT)
    |=> (state_r == MIT_ST_BUBBLE) [*4] ##1 state_r == MIT_ST_EXEC)
    else $error("branch did not take two cycles");
  table_a: assert property (exec && op == OP_TABRD |=> (state_r == MIT_ST_TABLE) [*4])
    else $error("table read did not take two cycles");
  pc_low_a: assert property (exec && wr_req && adr == ADDR_PC_LOW
    |=> state_r == MIT_ST_BUBBLE && pc_r[7:0] == $past(wdata))
    else $error("low pc write did not jump");
  skip_a: assert property (exec && skip
    |=> state_r == MIT_ST_BUBBLE && pc_r == 10'($past(pc_r) + 10'h002))
    else $error("taken skip wrong");
  noskip_a: assert property (exec && op == OP_SZ_M && opnd != 8'h00
    |=> state_r == MIT_ST_EXEC && pc_r == 10'($past(pc_r) + 10'h001))
    else $error("untaken skip wrong");
  call_save_a: assert property (exec && op == OP_CALL
    |=> stk_r[$past(sp_r)] == 10'($past(pc_r) + 10'h001))
    else $error("call saved wrong address");
  jmp_stack_a: assert property (exec && op == OP_JMP |=> $stable(sp_r))
    else $error("jump touched stack");
  mov_imm_a: assert property (exec && op == OP_MOV_AX |=> acc_r == $past(imm))
    else $error("immediate move wrong");
  add_carry_a: assert property (exec && op == OP_ADD_AX
    |=> status_r[ST_C] == (({1'b0, $past(acc_r)} + {1'b0, $past(imm)}) > 9'h0ff))
    else $error("add carry wrong");
  step_a: assert property (exec && op == OP_ADDONEA |=> acc_r == 8'($past(opnd) + 8'h01))
    else $error("increment wrong");
  zero_a: assert property (exec && op == OP_AND_AX |=> status_r[ST_Z] == (acc_r == 8'h00))
    else $error("logic zero flag wrong");
  rot_c_a: assert property (exec && op == OP_ROTLC_M && adr != ADDR_STATUS
    |=> status_r[ST_C] == $past(opnd[7]))
    else $error("rotate carry wrong");
  bit_set_a: assert property (exec && op == OP_SET_BIT && dmem_we
    |-> wdata[bsel] && ((wdata ^ opnd) & ~bmask) == 8'h00)
    else $error("bit set changed other bits");
  add_ov_a: assert property (exec && op == OP_ADD_AX
    |=> status_r[ST_OV] == ($past(acc_r[7]) == $past(imm[7]) && acc_r[7] != $past(acc_r[7])))
    else $error("add overflow wrong");

  call_c:  cover property (exec && op == OP_CALL);
  skip_c:  cover property (exec && skip);
  table_c: cover property (state_r == MIT_ST_TABLE && phase_r == PH_LAST);
  pclw_c:  cover property (exec && wr_req && adr == ADDR_PC_LOW);

endmodule // mit_core

// [testbench/mcu_instruction_timing_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module mcu_instruction_timing_bench
  import mit_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic            clk_sys = 1'b0;
  logic            rst_b = 1'b0;
  logic [15:0]     prog_data = 16'h0000;
  logic [PC_W-1:0] prog_addr, pc_out, pc, ret;
  logic [7:0]      acc_out, a, r;
  logic [3:0]      flags_out, f;
  logic [3:0]      cnt = 4'h0;
  logic [1:0]      phase_out;
  logic            instr_done, tk;
  logic [15:0]     rom [1024];
  logic [7:0]      mem [128];
  logic [25:0]     exq [$];
  logic [25:0]     e;
  logic [2:0]      b;
  int              seed = 32'h2d406dce;
  int              err_count = 0;
  int              checks_done = 0;
  logic [5:0]      rop [4] = '{OP_ROTLC_M, OP_ROTR_M, OP_ROTRC_M, OP_ROTL_M};
  logic [5:0]      sop [4] = '{OP_SZ_M, OP_SNZ_M, OP_SZ_BIT, OP_SNZ_BIT};
  logic [5:0]      aop [4] = '{OP_ADD_AM, OP_SUB_AM, OP_ADC_AM, OP_SBC_AM};

  mit_core DUT (
    .CLK_SYS    (clk_sys),
    .RST_B      (rst_b),
    .PROG_ADDR  (prog_addr),
    .PROG_DATA  (prog_data),
    .PC_OUT     (pc_out),
    .ACC_OUT    (acc_out),
    .FLAGS_OUT  (flags_out),
    .PHASE_OUT  (phase_out),
    .INSTR_DONE (instr_done)
  );

  initial forever #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) prog_data <= rom[prog_addr];

  // ------------------------------------------------------------
  // program builder with expected results
  // ------------------------------------------------------------
  task automatic put(input logic [5:0] op, input logic [9:0] fld, input logic [3:0] cyc);
    rom[pc] = {op, fld};
    exq.push_back({pc, cyc, f, a});
    pc = pc + 10'h001;
  endtask
  task automatic mark();
    rom[pc] = {OP_MOV_AX, 10'h0ee};
    pc = pc + 10'h001;
  endtask
  function automatic logic [9:0] mf(input logic [2:0] bi, input logic [6:0] m);
    return {bi, m};
  endfunction
  function automatic logic [11:0] arith(input logic [7:0] x, y, input logic ci, sb);
    logic [7:0] yy;
    logic       c0;
    logic [8:0] s;
    logic [4:0] h;
    yy = sb ? ~y : y;
    c0 = sb ? ~ci : ci;
    s = x + yy + c0;
    h = x[3:0] + yy[3:0] + c0;
    return {(x[7] == yy[7]) && (s[7] != x[7]), h[4] ^ sb, s[8] ^ sb, s[7:0] == 8'h00, s[7:0]};
  endfunction
  task automatic ar(input logic [5:0] op, input logic [7:0] y, input logic ci, sb,
                    input logic [9:0] fld);
    {f, a} = arith(a, y, ci, sb);
    put(op, fld, 4'h4);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 1024; i++) rom[i] = 16'h0000;
    pc = RST_PC;
    a = RST_ACC;
    f = RST_STATUS;
    put(OP_NOP, 10'h000, 4'h0);
    for (int i = 0; i < 8; i++) begin
      {a, r} = (i == 0) ? 16'hff01 : (i == 1) ? 16'h0001 : 16'($random(seed));
      put(OP_MOV_AX, {2'b00, a}, 4'h4);
      ar(i[0] ? OP_SUB_AX : OP_ADD_AX, r, 1'b0, i[0], {2'b00, r});
    end
    mem[7'h20] = a;
    put(OP_MOV_MA, mf(3'h0, 7'h20), 4'h4);
    for (int i = 0; i < 4; i++) ar(aop[i], mem[7'h20], i[1] & f[1], i[0], mf(3'h0, 7'h20));
    for (int i = 0; i < 3; i++) begin
      r = (i == 2) ? a : 8'($random(seed));
      a = (i == 0) ? a & r : (i == 1) ? a | r : a ^ r;
      f[0] = (a == 8'h00);
      put((i == 0) ? OP_AND_AX : (i == 1) ? OP_OR_AX : OP_XOR_AX, {2'b00, r}, 4'h4);
    end
    a = ~mem[7'h20];
    f[0] = (a == 8'h00);
    put(OP_COMPLA_M, mf(3'h0, 7'h20), 4'h4);
    a = 8'hff;
    put(OP_MOV_AX, 10'h0ff, 4'h4);
    mem[7'h21] = a;
    put(OP_MOV_MA, mf(3'h0, 7'h21), 4'h4);
    a = 8'h00;
    f[0] = 1'b1;
    put(OP_ADDONEA, mf(3'h0, 7'h21), 4'h4);
    mem[7'h21] = 8'hfe;
    f[0] = 1'b0;
    put(OP_SUBONE_M, mf(3'h0, 7'h21), 4'h4);
    for (int i = 0; i < 8; i++) begin
      b = 3'($random(seed));
      case (i)
        0: {f[1], mem[7'h21]} = {mem[7'h21], f[1]};
        1: mem[7'h21] = {mem[7'h21][0], mem[7'h21][7:1]};
        2: {mem[7'h21], f[1]} = {f[1], mem[7'h21]};
        3: mem[7'h21] = {mem[7'h21][6:0], mem[7'h21][7]};
        default: mem[7'h21][b] = i[0];
      endcase
      if (i < 4) put(rop[i], mf(3'h0, 7'h21), 4'h4);
      else put(i[0] ? OP_SET_BIT : OP_CLR_BIT, mf(b, 7'h21), 4'h4);
      a = mem[7'h21];
      put(OP_MOV_AM, mf(3'h0, 7'h21), 4'h4);
    end
    mem[7'h22] = 8'h00;
    put(OP_CLR_M, mf(3'h0, 7'h22), 4'h4);
    for (int i = 0; i < 4; i++) begin
      b = 3'($random(seed));
      tk = ((i < 2) ? (mem[7'h22] == 8'h00) : (mem[7'h21][b] == 1'b0)) ^ i[0];
      put(sop[i], mf(b, (i < 2) ? 7'h22 : 7'h21), tk ? 4'h8 : 4'h4);
      if (tk) mark();
    end
    put(OP_JMP, pc + 10'h002, 4'h8);
    mark();
    for (int i = 0; i < 2; i++) begin
      ret = pc + 10'h001;
      put(OP_CALL, 10'h0c0 + 10'(8 * i), 4'h8);
      pc = 10'h0c0 + 10'(8 * i);
      a = 8'($random(seed));
      put(OP_MOV_AX, {2'b00, a}, 4'h4);
      put(i[0] ? OP_INTEXIT : OP_SUBEXIT, 10'h000, 4'h8);
      pc = ret;
    end
    a = 8'hf0;
    put(OP_MOV_AX, 10'h0f0, 4'h4);
    rom[10'h0f0] = 16'($random(seed));
    put(OP_TABRD, mf(3'h0, 7'h23), 4'h8);
    a = rom[10'h0f0][7:0];
    put(OP_MOV_AM, mf(3'h0, 7'h23), 4'h4);
    a = rom[10'h0f0][15:8];
    put(OP_MOV_AM, mf(3'h0, ADDR_TBLH), 4'h4);
    a = 8'ha0;
    put(OP_MOV_AX, 10'h0a0, 4'h4);
    put(OP_MOV_MA, mf(3'h0, ADDR_PC_LOW), 4'h8);
    mark();
    pc = 10'h0a0;
    a = 8'h3c;
    put(OP_MOV_AX, 10'h03c, 4'h4);
    put(OP_JMP, pc, 4'h8);
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int k = 0; k < 2000 && exq.size() > 0; k++) @(negedge clk_sys);
    if (exq.size() > 0) err_count++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // result watcher and watchdog
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    cnt = cnt + 4'h1;
    if (instr_done === 1'b1 && exq.size() > 0) begin
      e = exq.pop_front();
      `CHK("acc", e[7:0], acc_out)
      `CHK("flags", e[11:8], flags_out)
      `CHK("phase", PH_FIRST, phase_out)
      if (e[15:12] != 4'h0) `CHK("cycles", e[15:12], cnt)
      if (exq.size() > 0) `CHK("pc", exq[0][25:16], pc_out)
      cnt = 4'h0;
    end
  end

  initial begin
    #50000;
    err_count++;
    tally_and_finish();
  end
endmodule // mcu_instruction_timing_bench
